// [design/bridge_drive_fault_protection.sv]
// Top of the two-phase bridge drive with fault protection and a Wishbone register port.
// Assumes all pin inputs except RST_N_I are synchronous to CORE_CLK_I and a classic Wishbone master.
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "bridge_drive_regs.svh"
module bridge_drive_fault_protection
  import bridge_drive_pkg::*;
#(
  parameter int OPEN_TIMEOUT_CYC = `OPEN_TIMEOUT_CYC,
  parameter int OPEN_PULSE_CYC   = `OPEN_PULSE_CYC,
  parameter int REGEN_CYC        = `REGEN_CYC,
  parameter int CLEAR_CYC        = `CLEAR_CYC
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        CHOP_REF_OSCILLATOR_I,
  input  wire logic        CURRENT_REACHED_A_I,
  input  wire logic        CURRENT_REACHED_B_I,
  input  wire logic [1:0]  UPPER_OC_I,
  input  wire logic [1:0]  SENSE_OC_I,
  input  wire logic        SHUTDOWN_TEMPERATURE_I,
  input  wire logic        TEMP_RECOVERED_I,
  output logic      [3:0]  BRIDGE_A_O,
  output logic      [3:0]  BRIDGE_B_O,
  output logic      [6:0]  CURRENT_SCALE_PCT_O,
  output logic             FAULT_FLAG_N_O
);
  localparam logic [15:0] PULSE_LAST = 16'(OPEN_PULSE_CYC - 1);
  localparam logic [15:0] CLEAR_LAST = 16'(CLEAR_CYC - 1);
  localparam logic [9:0]  ON_LAST    = 10'(`TURN_ON_CYC - 1);

  protect_if pif ();

  // Reset release through two flip-flops.
  logic       rst_meta_q;
  logic       rst_sync_q;
  wire        rst_n = rst_sync_q;

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Software-visible control.
  logic [4:0] ctrl_q;
  wire        enable    = ctrl_q[`CTRL_ENABLE_BIT];
  wire        sel0      = ctrl_q[`CTRL_SEL0_BIT];
  wire        sel1      = ctrl_q[`CTRL_SEL1_BIT];
  wire        reverse_a = ctrl_q[`CTRL_DIR_A_BIT];
  wire        reverse_b = ctrl_q[`CTRL_DIR_B_BIT];

  // Wishbone decode: one-cycle answer, unmapped words read zero and ignore writes.
  // A write lands at the edge where the master samples ack, not one edge earlier.
  logic       ack_q;
  wire        wb_req    = WB_CYC_I && WB_STB_I && !ack_q;
  wire [5:0]  word      = WB_ADR_I[7:2];
  wire        hit_ctrl  = word == `CTRL_OFS;
  wire        hit_stat  = word == `STATUS_OFS;
  wire        wr_ctrl   = WB_CYC_I && WB_STB_I && ack_q && WB_WE_I && hit_ctrl && WB_SEL_I[0];

  // Enable timing.
  logic       en_prev_q;
  logic [15:0] low_cnt_q;
  logic [9:0] on_cnt_q;
  logic       on_done_q;
  logic       clear_q;

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_prev_q <= 1'b0;
      low_cnt_q <= 16'h0;
      clear_q   <= 1'b0;
    end
    else
    begin
      en_prev_q <= enable;
      if (enable)
        low_cnt_q <= 16'h0;
      else if (low_cnt_q != CLEAR_LAST)
        low_cnt_q <= low_cnt_q + 16'h1;
      clear_q <= !enable && (low_cnt_q == CLEAR_LAST);
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_cnt_q  <= 10'h0;
      on_done_q <= 1'b0;
    end
    else if (!enable || (enable && !en_prev_q))
    begin
      on_cnt_q  <= 10'h0;
      on_done_q <= 1'b0;
    end
    else if (!on_done_q)
    begin
      on_cnt_q  <= on_cnt_q + 10'h1;
      on_done_q <= on_cnt_q == ON_LAST;
    end
  end

  assign pif.clear_req = clear_q;
  assign pif.temp_ok   = TEMP_RECOVERED_I;

  wire run = enable && on_done_q && !pif.tripped;

  // Reference oscillator edge.
  logic osc_prev_q;
  wire  osc_tick = CHOP_REF_OSCILLATOR_I && !osc_prev_q;

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      osc_prev_q <= 1'b0;
    else
      osc_prev_q <= CHOP_REF_OSCILLATOR_I;
  end

  logic [3:0] sw_a;
  logic [3:0] sw_b;
  chop_mode_t mode_a;
  chop_mode_t mode_b;
  logic       open_a;
  logic       open_b;

  phase_chopper #(
    .TIMEOUT_CYC (OPEN_TIMEOUT_CYC)
  ) u_phase_a (
    .clk_i      (CORE_CLK_I),
    .rst_n_i    (rst_n),
    .osc_tick_i (osc_tick),
    .run_i      (run),
    .reverse_i  (reverse_a),
    .reached_i  (CURRENT_REACHED_A_I),
    .sw_o       (sw_a),
    .mode_o     (mode_a),
    .open_evt_o (open_a)
  );

  phase_chopper #(
    .TIMEOUT_CYC (OPEN_TIMEOUT_CYC)
  ) u_phase_b (
    .clk_i      (CORE_CLK_I),
    .rst_n_i    (rst_n),
    .osc_tick_i (osc_tick),
    .run_i      (run),
    .reverse_i  (reverse_b),
    .reached_i  (CURRENT_REACHED_B_I),
    .sw_o       (sw_b),
    .mode_o     (mode_b),
    .open_evt_o (open_b)
  );

  fault_guard #(
    .REGEN_CYC (REGEN_CYC)
  ) u_guard (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (rst_n),
    .upper_oc_i  (UPPER_OC_I),
    .sense_oc_i  (SENSE_OC_I),
    .over_temp_i (SHUTDOWN_TEMPERATURE_I),
    .pif         (pif)
  );

  // Load-open pulse stretcher; an event during a running pulse is merged into it.
  logic [15:0] pulse_cnt_q;
  logic        pulse_q;

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulse_cnt_q <= 16'h0;
      pulse_q     <= 1'b0;
    end
    else if (!pulse_q && (open_a || open_b))
    begin
      pulse_cnt_q <= 16'h0;
      pulse_q     <= 1'b1;
    end
    else if (pulse_q)
    begin
      pulse_cnt_q <= pulse_cnt_q + 16'h1;
      pulse_q     <= pulse_cnt_q != PULSE_LAST;
    end
  end

  // Output drive: regeneration overrides the chopper on both phases.
  wire [3:0] out_a = pif.regen ? pif.regen_sw : (run ? sw_a : 4'h0);
  wire [3:0] out_b = pif.regen ? pif.regen_sw : (run ? sw_b : 4'h0);

  wire [31:0] status = {18'h0, mode_b, mode_a, pulse_q, run, pif.regen,
                        pif.ot_latched, pif.oc_latched, FAULT_FLAG_N_O};
  wire [31:0] rdata  = hit_ctrl ? {27'h0, ctrl_q} : (hit_stat ? status : 32'h0);

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q              <= `CTRL_RESET;
      ack_q               <= 1'b0;
      WB_DAT_O            <= 32'h0;
      BRIDGE_A_O          <= 4'h0;
      BRIDGE_B_O          <= 4'h0;
      CURRENT_SCALE_PCT_O <= `SCALE_FULL;
      FAULT_FLAG_N_O      <= 1'b1;
    end
    else
    begin
      ack_q    <= wb_req;
      WB_DAT_O <= (wb_req && !WB_WE_I) ? rdata : 32'h0;
      if (wr_ctrl)
        ctrl_q <= WB_DAT_I[4:0];
      BRIDGE_A_O <= out_a;
      BRIDGE_B_O <= out_b;
      CURRENT_SCALE_PCT_O <= torque_scale(sel0, sel1);
      FAULT_FLAG_N_O <= !(pif.fault_flag_n_low || pulse_q);
    end
  end

  assign WB_ACK_O = ack_q;
endmodule // bridge_drive_fault_protection

// [common/bridge_drive_regs.svh]
// Constants of the bridge drive and fault protection block: offsets, fields, timing.
// Assumes a 250 MHz core clock and a classic Wishbone slave at word offsets.
// Functional notes
// - Forward charge, slow and fast decay use the fixed forward switch patterns.
// - Reverse charge, slow and fast decay use the fixed reverse switch patterns.
// - Torque select codes give 100, 70, 50 or 30 percent current target.
// - Load-open timer starts at charge start, cleared by current reached.
// - Load-open timeout gives one 100 us low pulse on the fault flag.
// - Timer restarts at each charge start when idle; open load repeats pulses.
// - Reconnected load conducts again at the first charge after last timeout.
// - Upper-switch overcurrent above 2 A turns outputs off, fault flag low.
// - Overcurrent gives 5 ms regeneration, then latched off until cleared.
// - Fault flag falls 3.5 us after the overcurrent comparator rising edge.
// - Enable held low 0.2 ms clears the latch; fault flag rises then.
// - Outputs turn on 4 us after an enable rising edge.
// - Regeneration: uppers on for supply short, lowers on for ground short.
// - Sense voltage above 600 mV trips like the upper-switch path, but regeneration turns the uppers on instead of the lowers.
// - Overcurrent comparators are masked against short noise spikes.
// - At 175 C: 5 ms regeneration, outputs off, latched, fault flag low.
// - Thermal latch clears only after temperature falls below 165 C.
// - Chop period 16 reference clocks; charge, slow on reach, fast clocks 13-16.
`ifndef BRIDGE_DRIVE_REGS_SVH
`define BRIDGE_DRIVE_REGS_SVH

`define CLK_MHZ             250
`define OPEN_TIMEOUT_US     50000
`define OPEN_TIMEOUT_CYC    (`OPEN_TIMEOUT_US * `CLK_MHZ)
`define OPEN_PULSE_US       100
`define OPEN_PULSE_CYC      (`OPEN_PULSE_US * `CLK_MHZ)
`define REGEN_US            5000
`define REGEN_CYC           (`REGEN_US * `CLK_MHZ)
`define FAULT_FLAG_N_DELAY_NS       3500
`define FAULT_FLAG_N_DELAY_CYC      ((`FAULT_FLAG_N_DELAY_NS * `CLK_MHZ) / 1000)
`define CLEAR_US            200
`define CLEAR_CYC           (`CLEAR_US * `CLK_MHZ)
`define TURN_ON_NS          4000
`define TURN_ON_CYC         ((`TURN_ON_NS * `CLK_MHZ) / 1000)
`define MASK_NS             1000
`define MASK_CYC            ((`MASK_NS * `CLK_MHZ) / 1000)
`define CHOP_LAST_POS       4'hf
`define FAST_START_POS      4'hc

`define SCALE_FULL          7'h64
`define SCALE_70            7'h46
`define SCALE_50            7'h32
`define SCALE_30            7'h1e

`define CTRL_OFS            6'h00
`define STATUS_OFS          6'h01
`define CTRL_RESET          5'h00
`define CTRL_ENABLE_BIT     0
`define CTRL_SEL0_BIT       1
`define CTRL_SEL1_BIT       2
`define CTRL_DIR_A_BIT      3
`define CTRL_DIR_B_BIT      4

`endif

// [common/bridge_drive_pkg.sv]
// Types and shared decode functions of the bridge drive block.
// Assumes the constant header is on the include path.
`include "bridge_drive_regs.svh"
package bridge_drive_pkg;

  typedef enum logic [3:0] {
    CH_OFF    = 4'b0001,
    CH_CHARGE = 4'b0010,
    CH_SLOW   = 4'b0100,
    CH_FAST   = 4'b1000
  } chop_mode_t;

  typedef enum logic [2:0] {
    PG_RUN   = 3'b001,
    PG_REGEN = 3'b010,
    PG_LATCH = 3'b100
  } guard_state_t;

  // Switch vector order: upper_left, upper_right, lower_left, lower_right.
  typedef logic [3:0] bridge_sw_t;

  function automatic bridge_sw_t bridge_pattern(input chop_mode_t mode, input logic reverse);
    bridge_sw_t sw;
    sw = 4'h0;
    case (mode)
      CH_CHARGE: sw = reverse ? 4'h6 : 4'h9;
      CH_SLOW:   sw = 4'h3;
      CH_FAST:   sw = reverse ? 4'h9 : 4'h6;
      default:   sw = 4'h0;
    endcase
    return sw;
  endfunction

  function automatic logic [6:0] torque_scale(input logic sel0, input logic sel1);
    logic [6:0] pct;
    case ({sel1, sel0})
      2'b00:   pct = `SCALE_FULL;
      2'b01:   pct = `SCALE_70;
      2'b10:   pct = `SCALE_50;
      default: pct = `SCALE_30;
    endcase
    return pct;
  endfunction

endpackage

// [common/protect_if.sv]
// Carrier between the core and the fault guard: clear request and latched fault view.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface protect_if;
  logic       clear_req;
  logic       temp_ok;
  logic       tripped;
  logic       regen;
  logic [3:0] regen_sw;
  logic       fault_flag_n_low;
  logic       oc_latched;
  logic       ot_latched;

  modport guard (input clear_req, input temp_ok, output tripped, output regen,
                 output regen_sw, output fault_flag_n_low, output oc_latched, output ot_latched);
  modport core  (output clear_req, output temp_ok, input tripped, input regen,
                 input regen_sw, input fault_flag_n_low, input oc_latched, input ot_latched);
endinterface // protect_if

// [design/phase_chopper.sv]
// One phase of the mixed-decay chopper with its load-open timer.
// Assumes osc_tick is a one-cycle pulse per reference oscillator period.
`timescale 1ns/1ps
`include "bridge_drive_regs.svh"
module phase_chopper
  import bridge_drive_pkg::*;
#(
  parameter int TIMEOUT_CYC = `OPEN_TIMEOUT_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       osc_tick_i,
  input  wire logic       run_i,
  input  wire logic       reverse_i,
  input  wire logic       reached_i,
  output logic [3:0]      sw_o,
  output chop_mode_t      mode_o,
  output logic            open_evt_o
);
  localparam logic [23:0] TMO_LAST = 24'(TIMEOUT_CYC - 1);

  logic [3:0]  pos_q;
  logic [3:0]  pos_d;
  chop_mode_t  mode_q;
  chop_mode_t  mode_d;
  logic [23:0] tmr_q;
  logic        tmr_run_q;
  logic        open_evt_q;

  wire  [3:0]  pos_next     = pos_q + 4'h1;
  wire         charge_start = run_i && osc_tick_i && (pos_next == 4'h0);
  wire         timeout      = tmr_run_q && (tmr_q == TMO_LAST) && !reached_i;

  always_comb
  begin
    pos_d  = pos_q;
    mode_d = mode_q;
    if (!run_i)
    begin
      pos_d  = `CHOP_LAST_POS;
      mode_d = CH_OFF;
    end
    else
    begin
      if (osc_tick_i)
        pos_d = pos_next;
      if (charge_start)
        mode_d = CH_CHARGE;
      else if (osc_tick_i && pos_next == `FAST_START_POS)
        mode_d = CH_FAST;
      else if (mode_q == CH_CHARGE && reached_i)
        mode_d = CH_SLOW;
      else if (mode_q == CH_OFF)
        mode_d = CH_OFF;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pos_q  <= `CHOP_LAST_POS;
      mode_q <= CH_OFF;
      sw_o   <= 4'h0;
    end
    else
    begin
      pos_q  <= pos_d;
      mode_q <= mode_d;
      sw_o   <= bridge_pattern(mode_d, reverse_i);
    end
  end

  // load-open timer; a running timer ignores new charge starts.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tmr_q      <= 24'h0;
      tmr_run_q  <= 1'b0;
      open_evt_q <= 1'b0;
    end
    else
    begin
      open_evt_q <= timeout;
      if (!run_i || (tmr_run_q && reached_i) || timeout)
        tmr_run_q <= 1'b0;
      else if (charge_start && !tmr_run_q)
      begin
        tmr_run_q <= 1'b1;
        tmr_q     <= 24'h0;
      end
      else if (tmr_run_q)
        tmr_q <= tmr_q + 24'h1;
    end
  end

  assign mode_o     = mode_q;
  assign open_evt_o = open_evt_q;
endmodule // phase_chopper

// [design/fault_guard.sv]
// Overcurrent and thermal protection: masking, regeneration, latch and flag delay.
// Assumes comparator inputs are synchronous; clear_req is a level held while enable is low.
`timescale 1ns/1ps
`include "bridge_drive_regs.svh"
module fault_guard
  import bridge_drive_pkg::*;
#(
  parameter int REGEN_CYC = `REGEN_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] upper_oc_i,
  input  wire logic [1:0] sense_oc_i,
  input  wire logic       over_temp_i,
  protect_if.guard        pif
);
  localparam logic [20:0] REGEN_LAST = 21'(REGEN_CYC - 1);
  localparam logic [9:0]  MASK_LAST  = 10'(`MASK_CYC - 1);
  localparam logic [9:0]  FAULT_FLAG_N_LAST  = 10'(`FAULT_FLAG_N_DELAY_CYC - 1);

  guard_state_t st_q;
  guard_state_t st_d;
  logic [20:0]  regen_q;
  logic [9:0]   mask_q;
  logic [9:0]   dly_q;
  logic         dly_run_q;
  logic         oc_prev_q;
  logic         oc_q;
  logic         ot_q;
  logic         fault_flag_n_q;
  logic [3:0]   regen_sw_q;

  wire oc_raw   = |upper_oc_i || |sense_oc_i;
  wire oc_trip  = oc_raw && (mask_q == MASK_LAST);
  wire ot_trip  = over_temp_i;
  wire trip     = st_q == PG_RUN && (oc_trip || ot_trip);
  wire clr_ok   = pif.clear_req && (!ot_q || pif.temp_ok);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      PG_RUN:   if (trip) st_d = PG_REGEN;
      PG_REGEN: if (clr_ok) st_d = PG_RUN;
                else if (regen_q == REGEN_LAST) st_d = PG_LATCH;
      PG_LATCH: if (clr_ok) st_d = PG_RUN;
      default:  st_d = PG_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q      <= PG_RUN;
      regen_q   <= 21'h0;
      mask_q    <= 10'h0;
      oc_prev_q <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      oc_prev_q <= oc_raw;
      regen_q   <= (st_q == PG_REGEN) ? regen_q + 21'h1 : 21'h0;
      if (!oc_raw)
        mask_q <= 10'h0;
      else if (mask_q != MASK_LAST)
        mask_q <= mask_q + 10'h1;
    end
  end

  // latch and flag delay; a trip needs PG_RUN, so in the clear cycle the clear wins.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      oc_q       <= 1'b0;
      ot_q       <= 1'b0;
      fault_flag_n_q     <= 1'b0;
      dly_q      <= 10'h0;
      dly_run_q  <= 1'b0;
      regen_sw_q <= 4'h0;
    end
    else
    begin
      if (oc_raw && !oc_prev_q && st_q == PG_RUN)
      begin
        dly_run_q <= 1'b1;
        dly_q     <= 10'h0;
      end
      else if (dly_run_q && (oc_raw || oc_q))
      begin
        dly_q <= dly_q + 10'h1;
        if (dly_q == FAULT_FLAG_N_LAST)
          dly_run_q <= 1'b0;
      end
      else
        dly_run_q <= 1'b0;
      if (trip)
      begin
        oc_q       <= oc_trip;
        ot_q       <= ot_trip && !oc_trip;
        fault_flag_n_q     <= ot_trip && !oc_trip;
        regen_sw_q <= (!oc_trip || |upper_oc_i) ? 4'h3 : 4'hc;
      end
      else if (clr_ok && st_q != PG_RUN)
      begin
        oc_q   <= 1'b0;
        ot_q   <= 1'b0;
        fault_flag_n_q <= 1'b0;
      end
      else if (oc_q && dly_run_q && dly_q == FAULT_FLAG_N_LAST)
        fault_flag_n_q <= 1'b1;
    end
  end

  assign pif.tripped    = st_q != PG_RUN;
  assign pif.regen      = st_q == PG_REGEN;
  assign pif.regen_sw   = regen_sw_q;
  assign pif.fault_flag_n_low   = fault_flag_n_q;
  assign pif.oc_latched = oc_q;
  assign pif.ot_latched = ot_q;
endmodule // fault_guard

// [tb/drive_guard_sva.sv]
// Checker of the bridge drive top: bus handshake, switch patterns, trip timing.
// Assumes the bench keeps the outputs running before it raises an overcurrent.
`timescale 1ns/1ps
module drive_guard_sva #(
  parameter int REGEN_CYC = 300
) (
  input wire logic        CORE_CLK_I,
  input wire logic        RST_N_I,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  input wire logic [1:0]  UPPER_OC_I,
  input wire logic        SHUTDOWN_TEMPERATURE_I,
  input wire logic [3:0]  BRIDGE_A_O,
  input wire logic [3:0]  BRIDGE_B_O,
  input wire logic [6:0]  CURRENT_SCALE_PCT_O,
  input wire logic        FAULT_FLAG_N_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Counts how long the upper comparators have been high without a break.
  logic [15:0] oc_run_q;
  logic [15:0] oc_run_d;
  assign oc_run_d = (|UPPER_OC_I) ? oc_run_q + {15'h0, oc_run_q != 16'hffff} : 16'h0;
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    if (!RST_N_I) oc_run_q <= 16'h0;
    else oc_run_q <= oc_run_d;
  ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("read data outside ack");
  scale_codes_a: assert property (CURRENT_SCALE_PCT_O inside {7'h64, 7'h46, 7'h32, 7'h1e})
    else $error("current scale not a legal percentage");
  bridge_legal_a: assert property (BRIDGE_A_O inside {4'h0, 4'h9, 4'h6, 4'h3, 4'hc} &&
    BRIDGE_B_O inside {4'h0, 4'h9, 4'h6, 4'hc, 4'h3}) else $error("illegal switch pattern");
  oc_regen_a: assert property (oc_run_q inside {[260:REGEN_CYC + 240]} |->
    BRIDGE_A_O == 4'h3 && BRIDGE_B_O == 4'h3) else $error("no ground-short regeneration");
  oc_off_a: assert property (oc_run_q >= REGEN_CYC + 270 |->
    BRIDGE_A_O == 4'h0 && BRIDGE_B_O == 4'h0) else $error("outputs not off after regeneration");
  oc_flag_a: assert property (oc_run_q >= 900 |-> !FAULT_FLAG_N_O)
    else $error("fault flag high during overcurrent");
  flag_delay_a: assert property ($fell(FAULT_FLAG_N_O) && oc_run_q != 16'h0 |->
    oc_run_q inside {[870:884]}) else $error("fault flag delay wrong");
  hot_flag_a: assert property (SHUTDOWN_TEMPERATURE_I |-> ##[0:6] !FAULT_FLAG_N_O)
    else $error("fault flag high at shutdown temperature");
  cov_oc: cover property ($fell(FAULT_FLAG_N_O) && oc_run_q != 16'h0);
  cov_hot: cover property (SHUTDOWN_TEMPERATURE_I ##1 !FAULT_FLAG_N_O);
  cov_ack: cover property (WB_ACK_O);
endmodule // drive_guard_sva

bind bridge_drive_fault_protection drive_guard_sva #(.REGEN_CYC(REGEN_CYC)) u_sva (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .UPPER_OC_I(UPPER_OC_I),
  .SHUTDOWN_TEMPERATURE_I(SHUTDOWN_TEMPERATURE_I), .BRIDGE_A_O(BRIDGE_A_O),
  .BRIDGE_B_O(BRIDGE_B_O), .CURRENT_SCALE_PCT_O(CURRENT_SCALE_PCT_O),
  .FAULT_FLAG_N_O(FAULT_FLAG_N_O));

// [tb/host_model.sv]
// Host controller model: classic Wishbone master that sets enable and torque.
// Assumes one clock shared with the block; the bench's watchdog ends a hang.
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = dat_i;
    {cyc_o, stb_o} <= 2'b00;
  endtask
  // enable low, selects low
  // The latch only clears if enable stays low for the full hold time.
  task automatic clear_latch(input int hold);
    logic [31:0] q;
    xfer(8'h00, 1'b1, 32'h0, 4'hf, q);
    repeat (hold) @(posedge clk_i);
  endtask
endmodule // host_model

// [tb/tb.sv]
// Self-checking bench of the bridge drive with shortened timing parameters.
// Assumes the checker is bound to the top and the host model speaks Wishbone.
`timescale 1ns/1ps
module tb;
  import bridge_drive_pkg::*;
  typedef struct packed {logic [4:0] ctrl; logic [6:0] pct; bridge_sw_t chg; bridge_sw_t fst;} row_t;
  logic        clk, rst_n, osc, reached, hot, cool, cyc, stb, we, ack, flag;
  logic [1:0]  uoc, soc;
  logic [2:0]  div_q = 3'h0;
  logic [3:0]  sel, br_a, br_b;
  logic [6:0]  pct;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [1:0]  sc, sf, ss;
  int          miscompares, checked, n, temp;
  row_t rows [4] = '{'{5'h01, 7'h64, 4'h9, 4'h6}, '{5'h1b, 7'h46, 4'h6, 4'h9},
                     '{5'h05, 7'h32, 4'h9, 4'h6}, '{5'h1f, 7'h1e, 4'h6, 4'h9}};
  bridge_drive_fault_protection #(.OPEN_TIMEOUT_CYC(2000), .OPEN_PULSE_CYC(50),
    .REGEN_CYC(300), .CLEAR_CYC(100)) u_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CHOP_REF_OSCILLATOR_I(osc),
    .CURRENT_REACHED_A_I(reached), .CURRENT_REACHED_B_I(reached), .UPPER_OC_I(uoc),
    .SENSE_OC_I(soc), .SHUTDOWN_TEMPERATURE_I(hot), .TEMP_RECOVERED_I(cool),
    .BRIDGE_A_O(br_a), .BRIDGE_B_O(br_b), .CURRENT_SCALE_PCT_O(pct), .FAULT_FLAG_N_O(flag));
  host_model u_host (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // The reference clock runs free at one rising edge per eight core cycles.
  always @(posedge clk) div_q <= div_q + 3'h1;
  assign osc = div_q[2];
  // The die model trips at 175 C and reports recovery only below 165 C.
  assign hot  = temp >= 175;
  assign cool = temp < 165;
  task automatic cycles(input int k); repeat (k) @(posedge clk); endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] d); u_host.xfer(8'h00, 1'b1, d, 4'hf, q); endtask
  task automatic wait_flag(input logic v, input int lim);
    n = 0;
    while (flag !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    summarize();
  end
  initial
  begin
    {rst_n, reached, uoc, soc} = '0;
    temp = 25;
    cycles(2);
    rst_n <= 1'b1;
    cycles(3);
    chk("reset scale", 7'h64, pct);
    chk("reset flag", 1'b1, flag);
    chk("reset bridge", 8'h0, {br_a, br_b});
    u_host.xfer(8'h00, 1'b1, 32'h1, 4'h0, q);
    u_host.xfer(8'h00, 1'b0, 32'h0, 4'hf, q);
    chk("ctrl after sel0 low write", 32'h0, q);
    u_host.xfer(8'h20, 1'b0, 32'h0, 4'hf, q);
    chk("unmapped read", 32'h0, q);
    $display("end of test: reset");
    foreach (rows[i])
    begin
      reached <= 1'b0;
      wr({27'h0, rows[i].ctrl});
      cycles(950);
      u_host.xfer(8'h04, 1'b0, 32'h0, 4'hf, q);
      chk("running early", 1'b0, q[4]);
      cycles(100);
      u_host.xfer(8'h04, 1'b0, 32'h0, 4'hf, q);
      chk("running", 1'b1, q[4]);
      chk("scale", rows[i].pct, pct);
      {sc, sf, ss} = '0;
      repeat (200)
      begin
        @(posedge clk);
        sc |= {br_b === rows[i].chg, br_a === rows[i].chg};
        sf |= {br_b === rows[i].fst, br_a === rows[i].fst};
      end
      reached <= 1'b1;
      repeat (200)
      begin
        @(posedge clk);
        ss |= {br_b === 4'h3, br_a === 4'h3};
      end
      chk("charge", 2'b11, sc);
      chk("fast", 2'b11, sf);
      chk("slow", 2'b11, ss);
      wr(32'h0);
      cycles(2);
      chk("off", 8'h0, {br_a, br_b});
    end
    $display("end of test: rows");
    reached <= 1'b0;
    wr(32'h1);
    wait_flag(1'b0, 4000);
    wait_flag(1'b1, 200);
    chk("open pulse width", 50, n);
    wait_flag(1'b0, 2300);
    chk("open pulse repeats", 1'b0, flag);
    cycles(60);
    reached <= 1'b1;
    wait_flag(1'b0, 2500);
    chk("no pulse with current", 2500, n);
    ss = '0;
    repeat (128)
    begin
      @(posedge clk);
      ss[0] |= br_a === 4'h3;
    end
    chk("slow after reconnect", 1'b1, ss[0]);
    $display("end of test: load open");
    uoc <= 2'b01;
    cycles(10);
    uoc <= 2'b00;
    wait_flag(1'b0, 1200);
    chk("spike masked", 1200, n);
    uoc <= 2'b01;
    cycles(1000);
    uoc <= 2'b00;
    cycles(300);
    chk("latched off", 9'h0, {br_a, br_b, flag});
    u_host.clear_latch(90);
    chk("flag during hold", 1'b0, flag);
    cycles(20);
    chk("flag cleared", 1'b1, flag);
    wr(32'h1);
    cycles(1100);
    soc <= 2'b10;
    cycles(300);
    chk("supply regen", 8'hcc, {br_a, br_b});
    cycles(600);
    soc <= 2'b00;
    chk("sense latched", 9'h0, {br_a, br_b, flag});
    u_host.clear_latch(110);
    chk("sense cleared", 1'b1, flag);
    $display("end of test: overcurrent");
    wr(32'h1);
    cycles(1100);
    temp <= 180;
    cycles(100);
    chk("thermal regen", 8'h33, {br_a, br_b});
    cycles(300);
    temp <= 170;
    chk("thermal off", 9'h0, {br_a, br_b, flag});
    u_host.clear_latch(200);
    chk("hot latch kept", 1'b0, flag);
    temp <= 150;
    cycles(10);
    chk("cool latch cleared", 1'b1, flag);
    $display("end of test: thermal");
    summarize();
  end
endmodule // tb
